// [serial_timekeeping_sram_map.vh]
// Address map, field positions, reset values and timing counts of the
// serial timekeeping memory. Definitions only; included by the calendar, top module and bench files.
`ifndef SERIAL_TIMEKEEPING_SRAM_MAP_VH
`define SERIAL_TIMEKEEPING_SRAM_MAP_VH

`define MEM_WORDS        32768
`define ADDR_W           15
`define RAM_LIMIT        15'h7ff0
`define ADDR_STAMP_BASE  15'h7ff0
`define ADDR_TAMPER      15'h7ff6
`define ADDR_HUNDREDTHS  15'h7ff7
`define ADDR_CTRL        15'h7ff8
`define CTRL_RESET       8'h00
`define CTRL_HALT_BIT    7
`define TAMPER_FLAG_BIT  0

`define CAL_HUND         3'h0
`define CAL_SEC          3'h1
`define CAL_MIN          3'h2
`define CAL_HOUR         3'h3
`define CAL_DAY          3'h4
`define CAL_DATE         3'h5
`define CAL_MONTH        3'h6
`define CAL_YEAR         3'h7

`define OSC_HZ           16'h8000
`define HUND_STEP        16'h0064
`define CLK_KHZ          200000
`define RESET_HOLD_MS    200
`define FIFO_DEPTH       16
`define FIFO_AW          4

`endif

// [write_fifo.v]
// Synchronous FIFO of flip-flops carrying write requests to storage.
// Assumes one clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/100ps
module write_fifo
#(
  parameter WIDTH = 23,
  parameter DEPTH = 16,
  parameter AW    = 4
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire             ce,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
      if (push)
      begin
        store[wr_ptr] <= in_data;
        wr_ptr        <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// [bcd_calendar.v]
// BCD time and calendar counters advanced by a hundredths-of-second step.
// Assumes the step and load strobes are one-cycle pulses on clk.
`timescale 1ns/100ps
`include "serial_timekeeping_sram_map.vh"
module bcd_calendar
(
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  input  wire        step,
  input  wire        load_en,
  input  wire [2:0]  load_idx,
  input  wire [7:0]  load_data,
  output wire [63:0] time_flat
);
  reg [7:0] t [0:7];
  reg [7:0] last_date;
  integer   i;

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Leap years are those divisible by four, which holds until 2100.
  function is_leap;
    input [7:0] y;
    begin
      if (y[4])
        is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
        is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                  (y[3:0] == 4'h8);
    end
  endfunction

  always @*
  begin
    case (t[`CAL_MONTH])
      8'h02:   last_date = is_leap(t[`CAL_YEAR]) ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : pack
      assign time_flat[g*8 +: 8] = t[g];
    end
  endgenerate

  always @(posedge clk)
  begin
    if (reset)
    begin
      for (i = 0; i < 8; i = i + 1)
        t[i] <= 8'h00;
      t[`CAL_DAY]   <= 8'h01;
      t[`CAL_DATE]  <= 8'h01;
      t[`CAL_MONTH] <= 8'h01;
    end
    else if (ce)
    begin
      if (load_en)
        t[load_idx] <= load_data;
      else if (step)
      begin
        // Each field rolls only when all fields below it other than day rolled.
        t[`CAL_HUND] <= (t[`CAL_HUND] == 8'h99) ? 8'h00
                        : bcd_inc(t[`CAL_HUND]);
        if (t[`CAL_HUND] == 8'h99)
        begin
          t[`CAL_SEC] <= (t[`CAL_SEC] == 8'h59) ? 8'h00
                         : bcd_inc(t[`CAL_SEC]);
          if (t[`CAL_SEC] == 8'h59)
          begin
            t[`CAL_MIN] <= (t[`CAL_MIN] == 8'h59) ? 8'h00
                           : bcd_inc(t[`CAL_MIN]);
            if (t[`CAL_MIN] == 8'h59)
            begin
              t[`CAL_HOUR] <= (t[`CAL_HOUR] == 8'h23) ? 8'h00
                              : bcd_inc(t[`CAL_HOUR]);
              if (t[`CAL_HOUR] == 8'h23)
              begin
                t[`CAL_DAY] <= (t[`CAL_DAY] == 8'h07) ? 8'h01
                               : bcd_inc(t[`CAL_DAY]);
                t[`CAL_DATE] <= (t[`CAL_DATE] >= last_date) ? 8'h01
                                : bcd_inc(t[`CAL_DATE]);
                if (t[`CAL_DATE] >= last_date)
                begin
                  t[`CAL_MONTH] <= (t[`CAL_MONTH] == 8'h12) ? 8'h01
                                   : bcd_inc(t[`CAL_MONTH]);
                  if (t[`CAL_MONTH] == 8'h12)
                    t[`CAL_YEAR] <= (t[`CAL_YEAR] == 8'h99) ? 8'h00
                                    : bcd_inc(t[`CAL_YEAR]);
                end
              end
            end
          end
        end
      end
    end
  end
endmodule

// [serial_timekeeping_sram.v]
// Serial timekeeping memory: two-wire slave, 32K byte store, BCD clock,
// power-fail deselect, processor reset hold and tamper time-stamp.
// Assumes bus pins, oscillator tick, tamper and power sense are
// asynchronous to clk; open-drain pins are resolved outside.
//
// Contract
// - Store of 32768 bytes, read and written by the bus master.
// - Eight byte locations hold the clock counters in BCD.
// - Address pointer advances by one after every data byte.
// - Clock holds year to hundredths, 24-hour hours, all BCD.
// - Date rolls for 28, 29, 30 and 31 day months through 2099.
// - Location 7FF8h holds calibration and the write-clock bit; here bit 7 halts the counters and the other bits are only stored.
// - Counters advance from the 32.768 kHz oscillator timebase.
// - Addresses and data travel only over the two-wire serial bus.
// - Processor reset stays asserted until supply is stable.
// - On power failure, deselect the bus and keep time and memory.
// - Tamper input sets a flag and time-stamps the event.
// - 32752 bytes are plain storage without side effects.
`timescale 1ns/100ps
`include "serial_timekeeping_sram_map.vh"
module serial_timekeeping_sram
#(
  parameter [6:0] DEVICE_SELECT     = 7'h5a, // Arbitrary value.
  parameter       RESET_HOLD_CYCLES = `RESET_HOLD_MS * `CLK_KHZ
)
(
  input  wire clk,
  input  wire reset,
  input  wire ce,
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_out,
  output reg  sda_oe_n,
  input  wire osc_tick_in,
  input  wire tamper_sense_in,
  input  wire power_fail_threshold,
  output wire cpu_reset_out,
  output reg  cpu_reset_oe_n
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV  = 3'h1;
  localparam ST_AHI  = 3'h2;
  localparam ST_ALO  = 3'h3;
  localparam ST_WR   = 3'h4;
  localparam ST_RD   = 3'h5;

  // Two-flop synchronisers for every pin input.
  reg [4:0]  sync_a;
  reg [4:0]  sync_b;
  reg        scl_d;
  reg        sda_d;
  reg        osc_d;
  reg        tamper_d;

  reg [7:0]  mem [0:`MEM_WORDS-1];
  reg [2:0]  state;
  reg [3:0]  bit_cnt;
  reg [7:0]  shift;
  reg [7:0]  tx;
  reg [14:0] ptr;
  reg        master_ack;
  reg        rd_fresh;
  reg [7:0]  ctrl;
  reg        tamper_flag;
  reg [47:0] stamp;
  reg [15:0] frac;
  reg [25:0] hold_cnt;
  reg        fifo_in_valid;
  reg [22:0] fifo_in_data;

  wire        scl_s = sync_b[0];
  wire        sda_s = sync_b[1];
  wire        osc_s = sync_b[2];
  wire        tamper_s = sync_b[3];
  wire        pf_s = sync_b[4];
  wire        start_seen = scl_s && scl_d && sda_d && !sda_s;
  wire        stop_seen = scl_s && scl_d && !sda_d && sda_s;
  wire        scl_rise = scl_s && !scl_d;
  wire        scl_fall = !scl_s && scl_d;
  wire [7:0]  rx = shift;
  wire [14:0] ptr_inc = ptr + 15'h0001;
  wire [15:0] frac_sum = frac + `HUND_STEP;
  wire        osc_edge = osc_s && !osc_d;
  wire        step = osc_edge && (frac_sum >= `OSC_HZ) &&
                     !ctrl[`CTRL_HALT_BIT];
  wire [63:0] time_flat;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [22:0] fifo_out_data;
  wire [14:0] wr_addr = fifo_out_data[22:8];
  wire [7:0]  wr_data = fifo_out_data[7:0];
  // Storage stalls while the clock is stepping so a load never collides.
  wire        drain_ready = !step;
  wire        drain = fifo_out_valid && drain_ready;
  wire        cal_load = drain && is_clock_loc(wr_addr);

  assign sda_out = 1'b0;
  assign cpu_reset_out = 1'b0;

  function is_clock_loc;
    input [14:0] a;
    begin
      is_clock_loc = (a == `ADDR_HUNDREDTHS) || (a > `ADDR_CTRL);
    end
  endfunction

  function [2:0] cal_index;
    input [14:0] a;
    begin
      if (a == `ADDR_HUNDREDTHS)
        cal_index = `CAL_HUND;
      else
        cal_index = a[2:0];
    end
  endfunction

  // One function answers every read so the map has a single decoder.
  function [7:0] read_loc;
    input [14:0] a;
    begin
      if (a < `RAM_LIMIT)
        read_loc = mem[a];
      else if (is_clock_loc(a))
        read_loc = time_flat[cal_index(a)*8 +: 8];
      else if (a == `ADDR_CTRL)
        read_loc = ctrl;
      else if (a == `ADDR_TAMPER)
        read_loc = {7'h00, tamper_flag};
      else if (a < `ADDR_TAMPER)
        read_loc = stamp[(a - `ADDR_STAMP_BASE)*8 +: 8];
      else
        read_loc = 8'h00;
    end
  endfunction

  always @(posedge clk)
  begin
    if (reset)
    begin
      // Bus lines start at their idle high level so no false edge follows.
      sync_a   <= 5'h03;
      sync_b   <= 5'h03;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      osc_d    <= 1'b0;
      tamper_d <= 1'b0;
    end
    else if (ce)
    begin
      sync_a   <= {power_fail_threshold, tamper_sense_in, osc_tick_in,
                   sda_in, scl_in};
      sync_b   <= sync_a;
      scl_d    <= scl_s;
      sda_d    <= sda_s;
      osc_d    <= osc_s;
      tamper_d <= tamper_s;
    end
  end

  // Fractional divider: 100 steps per 32768 oscillator edges, exact mean.
  always @(posedge clk)
  begin
    if (reset)
      frac <= 16'h0000;
    else if (ce && osc_edge)
    begin
      if (frac_sum >= `OSC_HZ)
        frac <= frac_sum - `OSC_HZ;
      else
        frac <= frac_sum;
    end
  end

  // Processor reset is held through power failure and a settling time.
  always @(posedge clk)
  begin
    if (reset)
    begin
      hold_cnt       <= 26'h0000000;
      cpu_reset_oe_n <= 1'b0;
    end
    else if (ce)
    begin
      if (pf_s)
        hold_cnt <= 26'h0000000;
      else if (hold_cnt != RESET_HOLD_CYCLES[25:0])
        hold_cnt <= hold_cnt + 26'h0000001;
      cpu_reset_oe_n <= !pf_s &&
                        (hold_cnt == RESET_HOLD_CYCLES[25:0]);
    end
  end

  // Serial slave. Events are taken from the synchronised pins.
  always @(posedge clk)
  begin
    if (reset)
    begin
      state         <= ST_IDLE;
      bit_cnt       <= 4'h0;
      shift         <= 8'h00;
      tx            <= 8'h00;
      ptr           <= 15'h0000;
      master_ack    <= 1'b0;
      rd_fresh      <= 1'b0;
      sda_oe_n      <= 1'b1;
      fifo_in_valid <= 1'b0;
      fifo_in_data  <= 23'h000000;
    end
    else if (ce)
    begin
      fifo_in_valid <= 1'b0;
      if (pf_s || stop_seen)
      begin
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (start_seen)
      begin
        state    <= ST_DEV;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else if (state != ST_IDLE)
      begin
        if (scl_rise)
        begin
          if (bit_cnt < 4'h8)
            shift <= {shift[6:0], sda_s};
          else
            master_ack <= !sda_s;
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (scl_fall)
        begin
          if (bit_cnt == 4'h8)
          begin
            sda_oe_n <= 1'b1;
            case (state)
              ST_DEV:
              begin
                if (rx[7:1] == DEVICE_SELECT)
                begin
                  sda_oe_n <= 1'b0;
                  state    <= rx[0] ? ST_RD : ST_AHI;
                  tx       <= read_loc(ptr);
                  rd_fresh <= rx[0];
                end
                else
                  state <= ST_IDLE;
              end
              ST_AHI:
              begin
                ptr[14:8] <= rx[6:0];
                sda_oe_n  <= 1'b0;
                state     <= ST_ALO;
              end
              ST_ALO:
              begin
                ptr[7:0] <= rx;
                sda_oe_n <= 1'b0;
                state    <= ST_WR;
              end
              ST_WR:
              begin
                // A full queue refuses the byte with a not-acknowledge.
                if (fifo_in_ready)
                begin
                  fifo_in_valid <= 1'b1;
                  fifo_in_data  <= {ptr, rx};
                  ptr           <= ptr_inc;
                  sda_oe_n      <= 1'b0;
                end
              end
              ST_RD:
                sda_oe_n <= 1'b1;
              default:
                state <= ST_IDLE;
            endcase
          end
          else if (bit_cnt == 4'h9)
          begin
            bit_cnt  <= 4'h0;
            sda_oe_n <= 1'b1;
            rd_fresh <= 1'b0;
            // The select acknowledge leads straight into the pointed byte.
            if (state == ST_RD && rd_fresh)
              sda_oe_n <= tx[7];
            else if (state == ST_RD)
            begin
              ptr <= ptr_inc;
              if (master_ack)
              begin
                tx       <= read_loc(ptr_inc);
                sda_oe_n <= (read_loc(ptr_inc) >= 8'h80);
              end
              else
                state <= ST_IDLE;
            end
          end
          else if (state == ST_RD)
            sda_oe_n <= tx[3'h7 - bit_cnt[2:0]];
        end
      end
    end
  end

  // Storage, control, tamper and stamp updates.
  always @(posedge clk)
  begin
    if (reset)
    begin
      ctrl        <= `CTRL_RESET;
      tamper_flag <= 1'b0;
      stamp       <= 48'h000000000000;
    end
    else if (ce)
    begin
      if (drain && wr_addr < `RAM_LIMIT)
        mem[wr_addr] <= wr_data;
      if (drain && wr_addr == `ADDR_CTRL)
        ctrl <= wr_data;
      // Set wins over a clear arriving in the same cycle.
      if (tamper_s && !tamper_d)
      begin
        tamper_flag <= 1'b1;
        if (!tamper_flag)
          stamp <= {time_flat[`CAL_MONTH*8 +: 8],
                    time_flat[`CAL_DATE*8 +: 8],
                    time_flat[`CAL_HOUR*8 +: 8],
                    time_flat[`CAL_MIN*8 +: 8],
                    time_flat[`CAL_SEC*8 +: 8],
                    time_flat[`CAL_HUND*8 +: 8]};
      end
      else if (drain && wr_addr == `ADDR_TAMPER &&
               !wr_data[`TAMPER_FLAG_BIT])
        tamper_flag <= 1'b0;
    end
  end

  write_fifo
  #(
    .WIDTH (23),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  )
  queue
  (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  bcd_calendar clock_counters
  (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .step      (step),
    .load_en   (cal_load),
    .load_idx  (cal_index(wr_addr)),
    .load_data (wr_data),
    .time_flat (time_flat)
  );
endmodule

// [serial_timekeeping_sram_sva.sv]
// Pin checker of the serial timekeeping memory.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module serial_timekeeping_sram_sva
#(
  parameter RESET_HOLD_CYCLES = 20
)
(
  input wire clk,
  input wire reset,
  input wire ce,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire osc_tick_in,
  input wire tamper_sense_in,
  input wire power_fail_threshold,
  input wire cpu_reset_out,
  input wire cpu_reset_oe_n
);
  integer rel_cnt;
  integer low_cnt;
  default clocking cb @(posedge clk);
  endclocking
  // Both counters saturate so that long runs never wrap them.
  always @(posedge clk)
  begin
    if (reset)
      rel_cnt <= 0;
    else if (rel_cnt < 1000)
      rel_cnt <= rel_cnt + 1;
    if (reset || sda_oe_n)
      low_cnt <= 0;
    else if (low_cnt < 1000)
      low_cnt <= low_cnt + 1;
  end
  AST_RST_CPU: assert property (reset |=> !cpu_reset_oe_n)
    else $error("processor reset not held during reset");
  AST_RST_SDA: assert property (reset |=> sda_oe_n)
    else $error("data line driven during reset");
  AST_CPU_HOLD: assert property (disable iff (reset)
    rel_cnt < RESET_HOLD_CYCLES |-> !cpu_reset_oe_n)
    else $error("processor reset released too early");
  AST_CPU_REL: assert property (
    disable iff (reset || power_fail_threshold)
    rel_cnt == RESET_HOLD_CYCLES + 5 |-> cpu_reset_oe_n)
    else $error("processor reset not released");
  AST_PF_DESEL: assert property (disable iff (reset)
    power_fail_threshold [*6] |-> sda_oe_n)
    else $error("data line driven in power failure");
  AST_ACK_HOLD: assert property (disable iff (reset)
    $fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("data line low pulse too short");
  AST_OE_SCL_LOW: assert property (disable iff (reset)
    !power_fail_threshold && $changed(sda_oe_n) |-> !scl_in)
    else $error("data line changed while serial clock high");
  AST_OE_BOUND: assert property (disable iff (reset) low_cnt < 190)
    else $error("data line held low too long");
  AST_OPEN_DRAIN: assert property (disable iff (reset)
    !sda_out && !cpu_reset_out)
    else $error("open drain value not low");
  cover property (disable iff (reset) $fell(sda_oe_n));
  cover property (disable iff (reset) $rose(cpu_reset_oe_n));
  cover property (disable iff (reset) power_fail_threshold && sda_oe_n);
endmodule

bind serial_timekeeping_sram serial_timekeeping_sram_sva
  #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_sva
  (.clk(clk), .reset(reset), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .osc_tick_in(osc_tick_in),
   .tamper_sense_in(tamper_sense_in),
   .power_fail_threshold(power_fail_threshold),
   .cpu_reset_out(cpu_reset_out), .cpu_reset_oe_n(cpu_reset_oe_n));

// [bus_master_model.sv]
// Two-wire bus master model; clock and data released high when idle.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module bus_master_model
(
  input  wire clk,
  input  wire sda_line,
  output reg  scl,
  output reg  sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves mid-low so it never races the slave's own answer.
  task start;
    w(5);
    sda = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda = 1'b0;
    w(10);
    scl = 1'b0;
  endtask
  task stop;
    w(5);
    sda = 1'b0;
    w(5);
    scl = 1'b1;
    w(10);
    sda = 1'b1;
    w(10);
  endtask
  task bitx(input b, output rb);
    w(5);
    sda = b;
    w(5);
    scl = 1'b1;
    w(5);
    rb = sda_line;
    w(5);
    scl = 1'b0;
  endtask
  task xb(input [7:0] b, input a, output [7:0] rv, output k);
    for (int i = 7; i >= 0; i--)
      bitx(b[i], rv[i]);
    bitx(a, k);
  endtask
endmodule

// [tb_top.sv]
// Bench of the serial timekeeping memory driven by the bus master model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/100ps
`include "serial_timekeeping_sram_map.vh"
module tb_top;
  localparam [6:0] SEL  = 7'h5a; // Arbitrary select value.
  localparam       HOLD = 20;
  reg              clk;
  reg              reset;
  reg              osc;
  reg              tamper;
  reg              pf;
  wire             scl;
  wire             m_sda;
  wire             sda_out;
  wire             sda_oe_n;
  wire             cpu_out;
  wire             cpu_oe_n;
  wire             sda = m_sda & (sda_oe_n | sda_out);
  integer          err_count;
  integer          checked;
  logic [7:0]      q[$];
  logic [7:0]      r;
  logic            k;
  // Date, month, year, day, then the values one step past midnight.
  logic [7:0]      cal [4][8] = '{
    '{8'h28, 8'h02, 8'h23, 8'h03, 8'h01, 8'h03, 8'h23, 8'h04},
    '{8'h28, 8'h02, 8'h24, 8'h03, 8'h29, 8'h02, 8'h24, 8'h04},
    '{8'h30, 8'h04, 8'h23, 8'h05, 8'h01, 8'h05, 8'h23, 8'h06},
    '{8'h31, 8'h12, 8'h99, 8'h07, 8'h01, 8'h01, 8'h00, 8'h01}};

  bus_master_model m (.clk(clk), .sda_line(sda), .scl(scl), .sda(m_sda));

  serial_timekeeping_sram #(.DEVICE_SELECT(SEL), .RESET_HOLD_CYCLES(HOLD))
    u_dut (.clk(clk), .reset(reset), .ce(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .osc_tick_in(osc), .tamper_sense_in(tamper),
    .power_fail_threshold(pf), .cpu_reset_out(cpu_out),
    .cpu_reset_oe_n(cpu_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    osc = 1'b0;
    forever #24 osc = ~osc;
  end

  task chk(input [7:0] g, input [7:0] e);
    checked = checked + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  task sb(input [7:0] b);
    m.xb(b, 1'b1, r, k);
    chk({7'h00, k}, 8'h00);
  endtask
  task sel_addr(input [14:0] a);
    m.start();
    sb({SEL, 1'b0});
    sb({1'b0, a[14:8]});
    sb(a[7:0]);
  endtask
  task wr(input [14:0] a);
    sel_addr(a);
    foreach (q[i])
      sb(q[i]);
    m.stop();
  endtask
  task rdc(input [14:0] a);
    sel_addr(a);
    m.start();
    sb({SEL, 1'b1});
    foreach (q[i])
    begin
      m.xb(8'hff, i == q.size() - 1, r, k);
      chk(r, q[i]);
    end
    m.stop();
  endtask
  task setcal(input integer n);
    q = {8'h99, 8'ha5, 8'h59, 8'h59, 8'h23,
         cal[n][3], cal[n][0], cal[n][1], cal[n][2]};
    wr(`ADDR_HUNDREDTHS);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #450000;
    err_count = err_count + 1;
    complete_run();
  end

  initial
  begin
    err_count = 0;
    checked = 0;
    reset = 1'b1;
    tamper = 1'b0;
    pf = 1'b0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk({7'h00, cpu_oe_n}, 8'h00);
    repeat (HOLD + 10) @(negedge clk);
    chk({7'h00, cpu_oe_n}, 8'h01);
    q = {`CTRL_RESET, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    rdc(`ADDR_CTRL);
    endt("reset");
    q = {8'h11, 8'h22, 8'h33};
    wr(15'h1234);
    rdc(15'h1234);
    q = {8'hc3};
    wr(15'h0000);
    q = {8'h3c, 8'h77};
    wr(15'h7fef);
    q = {8'h3c, 8'h00};
    rdc(15'h7fef);
    endt("storage");
    // Halt first so no step slips in before the whole time is loaded.
    q = {8'h80};
    wr(`ADDR_CTRL);
    for (int n = 0; n < 4; n++)
    begin
      setcal(n);
      void'(q.pop_front());
      rdc(`ADDR_CTRL);
      q = {8'h25};
      wr(`ADDR_CTRL);
      repeat (4000) @(negedge clk);
      q = {8'ha5};
      wr(`ADDR_CTRL);
      q = {8'ha5, 8'h00, 8'h00, 8'h00,
           cal[n][7], cal[n][4], cal[n][5], cal[n][6]};
      rdc(`ADDR_CTRL);
    end
    endt("calendar");
    setcal(0);
    tamper = 1'b1;
    repeat (10) @(negedge clk);
    tamper = 1'b0;
    repeat (10) @(negedge clk);
    q = {8'h99, 8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h01};
    rdc(`ADDR_STAMP_BASE);
    q = {8'h00};
    wr(`ADDR_TAMPER);
    rdc(`ADDR_TAMPER);
    endt("tamper");
    q = {8'h23, 8'hc3};
    rdc(15'h7fff);
    endt("wrap");
    m.start();
    m.xb({~SEL, 1'b0}, 1'b1, r, k);
    chk({7'h00, k}, 8'h01);
    m.stop();
    pf = 1'b1;
    repeat (20) @(negedge clk);
    m.start();
    m.xb({SEL, 1'b0}, 1'b1, r, k);
    chk({7'h00, k}, 8'h01);
    m.stop();
    pf = 1'b0;
    repeat (20) @(negedge clk);
    q = {8'h11};
    rdc(15'h1234);
    endt("refusal");
    complete_run();
  end
endmodule
